//--- spc_pkg.sv
// Package: register map, field layout and codes of the socket power block
package spc_pkg;
  localparam logic [7:0] SUPPLY_OFS = 8'h10;
  localparam logic [7:0] CLKPM_OFS = 8'h20;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h30;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h34;
  localparam logic [7:0] SENSE_OFS = 8'h38;
  localparam int STOP_POLICY_BIT = 7;
  localparam int VCC_LSB = 4;
  localparam int VPP_LSB = 0;
  localparam int ACCESS_BIT = 25;
  localparam int MODE_BIT = 24;
  localparam int CLK_EN_BIT = 16;
  localparam int CLK_SEL_BIT = 0;
  localparam int RETEST_BIT = 14;
  localparam int FORCE_LSB = 10;
  localparam logic [2:0] PWR_OFF = 3'h0;
  localparam logic [2:0] VCC_RSVD1 = 3'h1;
  localparam logic [2:0] VPP_12V = 3'h1;
  localparam logic [2:0] PWR_5V = 3'h2;
  localparam logic [2:0] PWR_3V3 = 3'h3;
  localparam logic [2:0] PWR_XV = 3'h4;
  localparam logic [2:0] PWR_YV = 3'h5;
  localparam logic [3:0] SLOW_DIV = 4'hf;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam int IRQ_ACCESS = 0;
  localparam int IRQ_MODE = 1;
  localparam int IRQ_BAD_REQ = 2;
  typedef struct packed {
    logic [2:0] vcc;
    logic [2:0] vpp;
  } spc_supply_s;
  typedef struct packed {
    logic sel_write;
    logic [31:0] addr;
    logic write;
  } spc_req_s;
endpackage : spc_pkg

//--- spc_clk_gen.sv
// Card clock generator: stop, slow by sixteen or run, from sampled link clock
`timescale 1ns/1ns
module spc_clk_gen (
  input wire logic clk,
  input wire logic nrst,
  input wire logic link_clk,
  input wire logic idle_ok,
  input wire logic slow_mode,
  output logic card_clk,
  output logic changed
);
  logic s1_q, s2_q, s3_q;
  logic [3:0] div_q;
  logic edge_w;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= link_clk;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  assign edge_w = s2_q ^ s3_q;

  // Divider counts link rising edges and toggles every eighth so the slowed clock keeps 50% duty
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_q <= 4'h0;
      card_clk <= 1'b0;
      changed <= 1'b0;
    end else if (!idle_ok) begin
      div_q <= 4'h0;
      card_clk <= s2_q;
      changed <= 1'b0;
    end else if (slow_mode) begin
      changed <= 1'b1;
      if (edge_w && s2_q) begin
        div_q <= div_q + 4'h1;
        if (div_q[2:0] == 3'h7)
          card_clk <= ~card_clk;
      end
    end else begin
      card_clk <= 1'b0;
      changed <= 1'b1;
    end
  end

  property p_slow_hold;
    @(posedge clk) disable iff (!nrst)
    (idle_ok && slow_mode && !(edge_w && s2_q)) |=> $stable(card_clk);
  endproperty
  a_slow_hold: assert property (p_slow_hold)
    else $error("slowed clock moved off its divided edge");
endmodule : spc_clk_gen

//--- spc_top.sv
// Socket supply and card clock power management registers on AHB-Lite
`timescale 1ns/1ns
module spc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic link_clk,
  input wire logic card_access,
  input wire logic socket_idle,
  input wire logic host_clk_stopping,
  input wire logic [3:0] card_volt_ok,
  output logic [2:0] vcc_out,
  output logic [2:0] vpp_out,
  output logic card_clk,
  output logic irq
);
  logic [2:0] vcc_req_q, vpp_req_q;
  logic stop_policy_q, clk_en_q, clk_sel_q;
  logic supply_dis_q;
  logic access_q, mode_q;
  logic [2:0] irq_stat_q, irq_mask_q;
  spc_pkg::spc_req_s req_q;
  logic [1:0] acc_s_q, idle_s_q, host_s_q;
  logic [3:0] ok1_q, ok2_q;
  logic acc_prev_q;
  logic acc_edge;
  logic wr_phase, rd_take;
  logic [31:0] wofs;
  logic idle_ok, slow_mode, clk_changed, mode_prev_q;
  logic bad_req;
  logic vcc_ok_w, vpp_ok_w;
  logic [2:0] ev;

  // Pin inputs pass two flops before any logic reads them
  always_ff @(posedge clk) begin
    if (!nrst) begin
      acc_s_q <= 2'h0;
      idle_s_q <= 2'h0;
      host_s_q <= 2'h0;
      ok1_q <= 4'h0;
      ok2_q <= 4'h0;
      acc_prev_q <= 1'b0;
    end else begin
      acc_s_q <= {acc_s_q[0], card_access};
      idle_s_q <= {idle_s_q[0], socket_idle};
      host_s_q <= {host_s_q[0], host_clk_stopping};
      ok1_q <= card_volt_ok;
      ok2_q <= ok1_q;
      acc_prev_q <= acc_s_q[1];
    end
  end
  assign acc_edge = acc_s_q[1] & ~acc_prev_q;

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clk) begin
    if (!nrst) begin
      req_q <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        req_q.sel_write <= hsel & htrans[1];
        req_q.addr <= haddr;
        req_q.write <= hwrite;
      end
    end
  end
  assign wr_phase = req_q.sel_write & req_q.write;
  assign wofs = req_q.addr;
  // Read is decided at the address phase so hrdata is ready at data phase
  assign rd_take = hready & hsel & htrans[1] & ~hwrite;

  // Reserved codes are rejected at write; applied value never sees them
  assign bad_req = wr_phase && wofs[7:0] == spc_pkg::SUPPLY_OFS &&
    (hwdata[6:4] == spc_pkg::VCC_RSVD1 || hwdata[6:4] > spc_pkg::PWR_YV ||
     hwdata[2:0] > spc_pkg::PWR_YV);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vcc_req_q <= spc_pkg::PWR_OFF;
      vpp_req_q <= spc_pkg::PWR_OFF;
      stop_policy_q <= 1'b0;
    end else if (wr_phase && wofs[7:0] == spc_pkg::SUPPLY_OFS) begin
      stop_policy_q <= hwdata[spc_pkg::STOP_POLICY_BIT];
      if (!(hwdata[6:4] == spc_pkg::VCC_RSVD1 ||
            hwdata[6:4] > spc_pkg::PWR_YV))
        vcc_req_q <= hwdata[6:4];
      if (hwdata[2:0] <= spc_pkg::PWR_YV)
        vpp_req_q <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      supply_dis_q <= 1'b0;
    end else if (wr_phase && wofs[7:0] == spc_pkg::SENSE_OFS) begin
      if (hwdata[spc_pkg::RETEST_BIT])
        supply_dis_q <= 1'b0;
      else if (|hwdata[13:10])
        supply_dis_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      clk_en_q <= 1'b0;
      clk_sel_q <= 1'b0;
    end else if (wr_phase && wofs[7:0] == spc_pkg::CLKPM_OFS) begin
      clk_en_q <= hwdata[spc_pkg::CLK_EN_BIT];
      clk_sel_q <= hwdata[spc_pkg::CLK_SEL_BIT];
    end
  end

  // Supply other than a 12 V Vpp applied only when the card accepts the voltage
  function automatic logic volt_ok(input logic [2:0] code,
                                   input logic [3:0] ok);
    logic r;
    r = 1'b0;
    case (code)
      spc_pkg::PWR_OFF: r = 1'b1;
      spc_pkg::PWR_5V: r = ok[0];
      spc_pkg::PWR_3V3: r = ok[1];
      spc_pkg::PWR_XV: r = ok[2];
      spc_pkg::PWR_YV: r = ok[3];
      default: r = 1'b0;
    endcase
    return r;
  endfunction : volt_ok

  // A 12 V programming supply rides on an accepted Vcc
  assign vcc_ok_w = volt_ok(vcc_req_q, ok2_q);
  assign vpp_ok_w = (vpp_req_q == spc_pkg::VPP_12V) ||
    volt_ok(vpp_req_q, ok2_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      vcc_out <= spc_pkg::PWR_OFF;
      vpp_out <= spc_pkg::PWR_OFF;
    end else if (!supply_dis_q) begin
      if (vcc_ok_w) begin
        vcc_out <= vcc_req_q;
        if (vpp_ok_w)
          vpp_out <= vpp_req_q;
      end
    end
  end

  // Policy 0 also waits for the host clock to be stopping
  assign idle_ok = idle_s_q[1] &
    (stop_policy_q | host_s_q[1]);
  // Slowing is chosen only when enabled; otherwise stop, as default
  assign slow_mode =
    clk_en_q & clk_sel_q;

  spc_clk_gen u_clk_gen (
    .clk(clk),
    .nrst(nrst),
    .link_clk(link_clk),
    .idle_ok(idle_ok),
    .slow_mode(slow_mode),
    .card_clk(card_clk),
    .changed(clk_changed)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_q <= 1'b0;
      mode_prev_q <= 1'b0;
    end else begin
      mode_q <= clk_changed;
      mode_prev_q <= mode_q;
    end
  end

  // A new access wins over the clearing read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      access_q <= 1'b0;
    end else if (acc_edge) begin
      access_q <= 1'b1;
    end else if (rd_take && haddr[7:0] == spc_pkg::CLKPM_OFS) begin
      access_q <= 1'b0;
    end
  end

  assign ev = {bad_req, mode_q & ~mode_prev_q, acc_edge};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end else begin
      if (wr_phase && wofs[7:0] == spc_pkg::IRQ_STAT_OFS)
        irq_stat_q <= (irq_stat_q & ~hwdata[2:0]) | ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      if (wr_phase && wofs[7:0] == spc_pkg::IRQ_MASK_OFS)
        irq_mask_q <= hwdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // Read data registered at the address phase; reserved bits zero
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hrdata <= spc_pkg::RESET_WORD;
    end else if (rd_take) begin
      hrdata <= spc_pkg::RESET_WORD;
      unique case (haddr[7:0])
        spc_pkg::SUPPLY_OFS:
          hrdata <= {24'h0, stop_policy_q, vcc_req_q, 1'b0,
                     vpp_req_q};
        spc_pkg::CLKPM_OFS:
          hrdata <= {6'h0, access_q, mode_q, 7'h0, clk_en_q, 15'h0,
                     clk_sel_q};
        spc_pkg::IRQ_STAT_OFS: hrdata <= {29'h0, irq_stat_q};
        spc_pkg::IRQ_MASK_OFS: hrdata <= {29'h0, irq_mask_q};
        spc_pkg::SENSE_OFS: hrdata <= {31'h0, supply_dis_q};
        default: hrdata <= spc_pkg::RESET_WORD;
      endcase
    end
  end

  property p_access_clear;
    @(posedge clk) disable iff (!nrst)
    (rd_take && haddr[7:0] == spc_pkg::CLKPM_OFS && !acc_edge)
      |=> !access_q;
  endproperty
  a_access_clear: assert property (p_access_clear)
    else $error("access flag not cleared by read");

  property p_access_set;
    @(posedge clk) disable iff (!nrst) acc_edge |=> access_q;
  endproperty
  a_access_set: assert property (p_access_set)
    else $error("access flag not set");

  property p_supply_reserved_bits;
    @(posedge clk) disable iff (!nrst)
    (rd_take && haddr[7:0] == spc_pkg::SUPPLY_OFS)
      |=> hrdata[31:8] == 24'h0 && !hrdata[3];
  endproperty
  a_supply_reserved_bits: assert property (p_supply_reserved_bits)
    else $error("supply reserved bits nonzero");

  property p_pm_reserved_bits;
    @(posedge clk) disable iff (!nrst)
    (rd_take && haddr[7:0] == spc_pkg::CLKPM_OFS)
      |=> hrdata[31:26] == 6'h0 && hrdata[23:17] == 7'h0 &&
          hrdata[15:1] == 15'h0;
  endproperty
  a_pm_reserved_bits: assert property (p_pm_reserved_bits)
    else $error("management reserved bits nonzero");

  property p_vcc_legal;
    @(posedge clk) disable iff (!nrst)
    vcc_out != spc_pkg::VCC_RSVD1 && vcc_out <= spc_pkg::PWR_YV;
  endproperty
  a_vcc_legal: assert property (p_vcc_legal)
    else $error("reserved vcc code applied");

  property p_vcc_accepted;
    @(posedge clk) disable iff (!nrst)
    $changed(vcc_out) |-> $past(vcc_ok_w) && !$past(supply_dis_q);
  endproperty
  a_vcc_accepted: assert property (p_vcc_accepted)
    else $error("vcc applied at unaccepted voltage");

  property p_forced_hold;
    @(posedge clk) disable iff (!nrst)
    supply_dis_q ##1 supply_dis_q |-> $stable(vcc_out);
  endproperty
  a_forced_hold: assert property (p_forced_hold)
    else $error("supply changed while disabled");

  property p_retest;
    @(posedge clk) disable iff (!nrst)
    (wr_phase && wofs[7:0] == spc_pkg::SENSE_OFS &&
     hwdata[spc_pkg::RETEST_BIT]) |=> !supply_dis_q;
  endproperty
  a_retest: assert property (p_retest)
    else $error("retest did not re-enable supply");

  property p_policy0;
    @(posedge clk) disable iff (!nrst)
    (!stop_policy_q && !host_s_q[1]) |=> !clk_changed;
  endproperty
  a_policy0: assert property (p_policy0)
    else $error("clock stop allowed without host stop");

  property p_disabled_stop;
    @(posedge clk) disable iff (!nrst)
    (!clk_en_q && idle_ok) [*3] |-> !card_clk;
  endproperty
  a_disabled_stop: assert property (p_disabled_stop)
    else $error("clock not stopped while control disabled");

  property p_vpp_accepted;
    @(posedge clk) disable iff (!nrst)
    $changed(vpp_out) |-> $past(vpp_ok_w) && $past(vcc_ok_w);
  endproperty
  a_vpp_accepted: assert property (p_vpp_accepted)
    else $error("vpp applied at unaccepted voltage");

  property p_reserved_bits_kept;
    @(posedge clk) disable iff (!nrst)
    (wr_phase && wofs[7:0] == spc_pkg::SUPPLY_OFS &&
     hwdata[6:4] == spc_pkg::VCC_RSVD1) |=> $stable(vcc_req_q);
  endproperty
  a_reserved_bits_kept: assert property (p_reserved_bits_kept)
    else $error("reserved vcc request was stored");

  property p_vcc_write;
    @(posedge clk) disable iff (!nrst)
    (wr_phase && wofs[7:0] == spc_pkg::SUPPLY_OFS &&
     hwdata[6:4] == spc_pkg::PWR_3V3) |=> vcc_req_q == spc_pkg::PWR_3V3;
  endproperty
  a_vcc_write: assert property (p_vcc_write)
    else $error("3.3 V request not stored");
endmodule : spc_top

//--- spc_card_model.sv
// Card in the socket: free-running link clock, accepted supplies, accesses
`timescale 1ns/1ns
module spc_card_model (
  input wire logic clk,
  input wire logic do_access,
  input wire logic [3:0] accept,
  output logic link_clk,
  output logic card_access,
  output logic [3:0] card_volt_ok
);
  int hold = 0;
  // The card tells which supplies it takes
  assign card_volt_ok = accept;
  // Phase kept off the system clock edges, at eight system clock periods per link period
  initial begin
    link_clk = 1'b0;
    #73;
    forever #200 link_clk = ~link_clk;
  end
  // Access held four cycles so the synchroniser cannot miss it
  always @(posedge clk) begin
    if (hold != 0)
      hold <= hold - 1;
    else if (do_access)
      hold <= 4;
  end
  assign card_access = (hold != 0);
endmodule : spc_card_model

//--- test_socket_power_clock_control.sv
// Testbench of the socket supply and card clock registers
`timescale 1ns/1ns
module test_socket_power_clock_control;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic idle = 1'b0;
  logic host_stop = 1'b0;
  logic do_acc = 1'b0;
  logic [3:0] accept = 4'hf;
  logic [31:0] hrdata;
  logic hreadyout, hresp, link_clk, card_access, card_clk, irq;
  logic [3:0] volt_ok;
  logic [2:0] vcc_out, vpp_out;
  logic [31:0] rd;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;

  spc_top i_dut (.clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link_clk(link_clk), .card_access(card_access),
    .socket_idle(idle), .host_clk_stopping(host_stop),
    .card_volt_ok(volt_ok), .vcc_out(vcc_out), .vpp_out(vpp_out),
    .card_clk(card_clk), .irq(irq));

  spc_card_model i_card (.clk(clk), .do_access(do_acc), .accept(accept),
    .link_clk(link_clk), .card_access(card_access),
    .card_volt_ok(volt_ok));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  // One single AHB-Lite transfer; read data taken at the data phase edge
  task automatic bus(input logic [7:0] a, input logic w,
                     input logic [31:0] wd);
    haddr <= {24'h0, a};
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask : rc

  task automatic wt(input int k);
    repeat (k) @(posedge clk);
  endtask : wt

  // Counts card clock changes over 64 link periods
  task automatic cnt();
    logic p;
    n = 0;
    p = card_clk;
    repeat (512) begin
      @(posedge clk);
      if (card_clk !== p)
        n++;
      p = card_clk;
    end
  endtask : cnt

  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rc(spc_pkg::SUPPLY_OFS, 32'h0);
    rc(spc_pkg::CLKPM_OFS, 32'h0);
    chk(32'({hreadyout, hresp}), 32'h2);
    wr(8'h3c, 32'hffff_ffff);
    rc(8'h3c, 32'h0);
    wr(spc_pkg::SUPPLY_OFS, 32'hffff_ffa9);
    rc(spc_pkg::SUPPLY_OFS, 32'h0000_00a1);
    wt(4);
    chk(32'(vcc_out), 32'(spc_pkg::PWR_5V));
    chk(32'(vpp_out), 32'(spc_pkg::VPP_12V));
    // Reserved Vcc code with interrupts masked, then unmasked
    wr(spc_pkg::IRQ_MASK_OFS, 32'h0);
    wr(spc_pkg::SUPPLY_OFS, 32'h0000_0092);
    rc(spc_pkg::SUPPLY_OFS, 32'h0000_00a2);
    wt(4);
    chk(32'(vcc_out), 32'(spc_pkg::PWR_5V));
    rc(spc_pkg::IRQ_STAT_OFS, 32'h4);
    chk(32'(irq), 32'h0);
    wr(spc_pkg::IRQ_MASK_OFS, 32'h7);
    wt(3);
    chk(32'(irq), 32'h1);
    wr(spc_pkg::IRQ_STAT_OFS, 32'h4);
    wt(3);
    chk(32'(irq), 32'h0);
    rc(spc_pkg::IRQ_STAT_OFS, 32'h0);
    // Card refuses 3.3 V
    accept <= 4'h1;
    wt(4);
    wr(spc_pkg::SUPPLY_OFS, 32'h0000_00b2);
    wt(4);
    chk(32'(vcc_out), 32'(spc_pkg::PWR_5V));
    // Forced voltage type blocks requests until a retest
    wr(spc_pkg::SENSE_OFS, 32'h0000_0400);
    rc(spc_pkg::SENSE_OFS, 32'h1);
    accept <= 4'hf;
    wr(spc_pkg::SUPPLY_OFS, 32'h0000_0080);
    wt(4);
    chk(32'(vcc_out), 32'(spc_pkg::PWR_5V));
    wr(spc_pkg::SENSE_OFS, 32'h0000_4000);
    rc(spc_pkg::SENSE_OFS, 32'h0);
    wr(spc_pkg::SUPPLY_OFS, 32'h0000_0045);
    wt(4);
    chk(32'(vcc_out), 32'(spc_pkg::PWR_XV));
    chk(32'(vpp_out), 32'(spc_pkg::PWR_YV));
    wr(spc_pkg::SUPPLY_OFS, 32'h0);
    wt(4);
    chk(32'(vcc_out), 32'(spc_pkg::PWR_OFF));
    chk(32'(vpp_out), 32'(spc_pkg::PWR_OFF));
    // Card access flag, cleared by reading
    do_acc <= 1'b1;
    @(posedge clk);
    do_acc <= 1'b0;
    wt(8);
    rc(spc_pkg::IRQ_STAT_OFS, 32'h1);
    rc(spc_pkg::CLKPM_OFS, 32'h0200_0000);
    rc(spc_pkg::CLKPM_OFS, 32'h0);
    wr(spc_pkg::IRQ_STAT_OFS, 32'h1);
    // Card clock policies
    idle <= 1'b1;
    cnt();
    chk(32'(n >= 100), 32'h1);
    rc(spc_pkg::CLKPM_OFS, 32'h0);
    host_stop <= 1'b1;
    wt(8);
    cnt();
    chk(32'(n), 32'h0);
    rc(spc_pkg::CLKPM_OFS, 32'h0100_0000);
    host_stop <= 1'b0;
    wr(spc_pkg::SUPPLY_OFS, 32'h0000_0080);
    wt(8);
    cnt();
    chk(32'(n), 32'h0);
    wr(spc_pkg::CLKPM_OFS, 32'hffff_ffff);
    wt(8);
    cnt();
    chk(32'(n >= 7 && n <= 9), 32'h1);
    rc(spc_pkg::CLKPM_OFS, 32'h0101_0001);
    wr(spc_pkg::CLKPM_OFS, 32'h0001_0000);
    wt(8);
    cnt();
    chk(32'(n), 32'h0);
    wr(spc_pkg::CLKPM_OFS, 32'h1);
    wt(8);
    cnt();
    chk(32'(n), 32'h0);
    idle <= 1'b0;
    wt(8);
    cnt();
    chk(32'(n >= 100), 32'h1);
    rc(spc_pkg::CLKPM_OFS, 32'h1);
    rc(spc_pkg::IRQ_STAT_OFS, 32'h2);
    chk(32'(irq), 32'h1);
    complete_run();
  end
endmodule : test_socket_power_clock_control
